// ---- verilog/supervisor_reset_watchdog_logic.sv ----
// Supply supervisor: reset stretcher, independent watchdog and power-fail flag.
//
// Notes on behaviour
// R1 - Manual reset low starts a reset pulse.
// R2 - Unconnected manual reset reads as inactive high.
// R3 - Power-fail flag low while sense is low.
// R4 - No kick edge for timeout expires watchdog.
// R5 - Floating kick input disables the watchdog.
// R6 - Timer clears on reset, float, kick edges.
// R7 - Reset pulse lasts the nominal reset duration.
// R8 - Reset held low while supply is low.
// R9 - Reset stays low full duration after release.
// R10 - Watchdog expiry never asserts reset by itself.
// R11 - Expired output stays low until timer cleared.
// R12 - Watchdog output low during supply low.
// R13 - Watchdog output rises at once with supply.
// R14 - Intervals come from counters on the clock.
`timescale 1ns/1ps
module supervisor_reset_watchdog_logic #(
	parameter longint unsigned RESET_CYCLES = supervisor_pkg::RESET_CYCLES,
	parameter longint unsigned WD_CYCLES    = supervisor_pkg::WD_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_supply_low,
	input  wire logic i_manual_reset_n,
	input  wire logic i_power_fail_sense_in,
	input  wire logic i_watchdog_kick_in,
	input  wire logic i_watchdog_kick_float,
	output logic      o_reset_n,
	output logic      o_watchdog_expired_n,
	output logic      o_power_fail_flag_n
);
	localparam int W = supervisor_pkg::CNT_W;

	// The release check below needs room for eight low cycles, so shorter pulses are refused.
	if (RESET_CYCLES < 9 || RESET_CYCLES >= (64'h1 << W) || WD_CYCLES < 2 || WD_CYCLES >= (64'h1 << W)) begin : g_bad_counts
		$error("supervisor counts out of range");
	end

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	// Each pin passes three flops; a change is taken once stages two and three agree.
	logic [2:0] sup_q, mr_q, pfi_q, wdi_q, flt_q;
	logic       sup_s_q, mr_s_q, pfi_s_q, wdi_s_q, flt_s_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sup_q <= supervisor_pkg::SYNC_HIGH_RESET;
			mr_q  <= supervisor_pkg::SYNC_HIGH_RESET; // [R2]
			pfi_q <= supervisor_pkg::SYNC_LOW_RESET;
			wdi_q <= supervisor_pkg::SYNC_LOW_RESET;
			flt_q <= supervisor_pkg::SYNC_HIGH_RESET;
		end else begin
			sup_q <= {sup_q[1:0], i_supply_low};
			mr_q  <= {mr_q[1:0], i_manual_reset_n};
			pfi_q <= {pfi_q[1:0], i_power_fail_sense_in};
			wdi_q <= {wdi_q[1:0], i_watchdog_kick_in};
			flt_q <= {flt_q[1:0], i_watchdog_kick_float};
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sup_s_q <= 1'h1;
			mr_s_q  <= 1'h1;
			pfi_s_q <= 1'h0;
			wdi_s_q <= 1'h0;
			flt_s_q <= 1'h1;
		end else begin
			if (sup_q[1] == sup_q[2]) sup_s_q <= sup_q[2];
			if (mr_q[1] == mr_q[2]) mr_s_q <= mr_q[2];
			if (pfi_q[1] == pfi_q[2]) pfi_s_q <= pfi_q[2];
			if (wdi_q[1] == wdi_q[2]) wdi_s_q <= wdi_q[2];
			if (flt_q[1] == flt_q[2]) flt_s_q <= flt_q[2];
		end
	end

	// ****************************************************************
	// Reset stretcher
	// ****************************************************************
	// Any low cause holds the counter at zero; release waits the full duration.
	logic         rst_cause;
	logic [W-1:0] rst_cnt_q;

	assign rst_cause = sup_s_q | ~mr_s_q; // [R1] [R8] [R10]

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rst_cnt_q <= '0;
		end else if (rst_cause) begin
			rst_cnt_q <= '0; // [R9]
		end else if (rst_cnt_q < W'(RESET_CYCLES)) begin
			rst_cnt_q <= rst_cnt_q + 1'b1; // [R14]
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reset_n <= supervisor_pkg::RST_OUT_RESET;
		end else begin
			o_reset_n <= !rst_cause && (rst_cnt_q >= W'(RESET_CYCLES) - 1'b1); // [R7] [R9]
		end
	end

	// ****************************************************************
	// Watchdog
	// ****************************************************************
	logic         wdi_prev_q;
	logic         wd_clear;
	logic [W-1:0] wd_cnt_q;
	logic         wd_fired_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wdi_prev_q <= 1'h0;
		end else begin
			wdi_prev_q <= wdi_s_q;
		end
	end

	// The stretched reset also clears the timer, so a host gets a fresh window after boot.
	assign wd_clear = !o_reset_n || flt_s_q || (wdi_s_q != wdi_prev_q); // [R5] [R6]

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wd_cnt_q <= '0;
		end else if (wd_clear) begin
			wd_cnt_q <= '0; // [R6]
		end else if (wd_cnt_q < W'(WD_CYCLES)) begin
			wd_cnt_q <= wd_cnt_q + 1'b1; // [R14]
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wd_fired_q <= 1'h0;
		end else if (wd_clear) begin
			wd_fired_q <= 1'h0; // [R11]
		end else if (wd_cnt_q == W'(WD_CYCLES) - 1'b1) begin
			wd_fired_q <= 1'h1; // [R4]
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_watchdog_expired_n <= supervisor_pkg::WDO_RESET;
		end else begin
			o_watchdog_expired_n <= !sup_s_q && !(wd_fired_q && !wd_clear); // [R12] [R13] [R11]
		end
	end

	// ****************************************************************
	// Power-fail flag
	// ****************************************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_power_fail_flag_n <= supervisor_pkg::PFO_RESET;
		end else begin
			o_power_fail_flag_n <= pfi_s_q; // [R3]
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	chk_reset_on_cause: assert property (rst_cause |=> !o_reset_n) // [R8]
		else $error("reset output high while a cause is present");
	chk_manual_reset: assert property ($fell(mr_s_q) |=> !o_reset_n) // [R1]
		else $error("manual reset did not start a reset pulse");
	chk_reset_stretch: assert property ($fell(rst_cause) |=> !o_reset_n [*8]) // [R9] [R7]
		else $error("reset released early after cause ended");
	chk_reset_count: assert property (!rst_cause && rst_cnt_q == W'(RESET_CYCLES) - 1'b1 |=> o_reset_n) // [R7]
		else $error("reset did not release after its duration");
	// A released reset may only fall again through a cause, never through a watchdog expiry.
	chk_no_wd_reset: assert property (o_reset_n && !rst_cause |=> o_reset_n) // [R10]
		else $error("watchdog affected reset");
	chk_rst_cnt_hold: assert property (rst_cause |=> rst_cnt_q == '0) // [R9]
		else $error("reset counter not held while a cause is present");
	chk_pfo_follow: assert property (o_power_fail_flag_n == $past(pfi_s_q)) // [R3]
		else $error("power-fail flag does not follow sense");
	chk_wd_clear: assert property (wd_clear |=> wd_cnt_q == '0 && !wd_fired_q) // [R6] [R5]
		else $error("watchdog timer not cleared");
	sequence wd_last_count;
		!wd_clear && wd_cnt_q == W'(WD_CYCLES) - 1'b1;
	endsequence

	sequence wd_still_armed;
		!wd_clear && !sup_s_q;
	endsequence

	chk_wd_expire: assert property (wd_last_count ##1 wd_still_armed |=> !o_watchdog_expired_n) // [R4]
		else $error("watchdog did not expire");
	chk_wd_cnt_sat: assert property (wd_cnt_q <= W'(WD_CYCLES)) // [R14]
		else $error("watchdog counter ran past its timeout");
	chk_wd_float_off: assert property (flt_s_q && !sup_s_q |=> o_watchdog_expired_n) // [R5]
		else $error("watchdog output low while kick input floats");
	chk_wd_hold: assert property (wd_fired_q && !wd_clear |=> wd_fired_q || wd_clear) // [R11]
		else $error("watchdog expiry dropped without clear");
	chk_wdo_low_supply: assert property (sup_s_q |=> !o_watchdog_expired_n) // [R12]
		else $error("watchdog output high during supply low");
	chk_wdo_rise: assert property ($fell(sup_s_q) && !wd_fired_q |=> o_watchdog_expired_n) // [R13]
		else $error("watchdog output delayed on supply recovery");
endmodule : supervisor_reset_watchdog_logic

// ---- verilog/supervisor_pkg.sv ----
// Constants shared by the supply supervisor logic.
package supervisor_pkg;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_PS   = 4000;
	localparam longint unsigned RESET_TIME_MS   = 200;
	localparam longint unsigned WD_TIMEOUT_MS   = 1600;
	localparam longint unsigned RESET_CYCLES    = (RESET_TIME_MS * 1000000000) / CLK_PERIOD_PS;
	localparam longint unsigned WD_CYCLES       = (WD_TIMEOUT_MS * 1000000000) / CLK_PERIOD_PS;
	localparam int unsigned CNT_W           = 32;
	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic        RST_OUT_RESET   = 1'h0;
	localparam logic        WDO_RESET       = 1'h0;
	localparam logic        PFO_RESET       = 1'h0;
	localparam logic [2:0]  SYNC_HIGH_RESET = 3'h7;
	localparam logic [2:0]  SYNC_LOW_RESET  = 3'h0;
endpackage : supervisor_pkg

// ---- verification/host_kicker.sv ----
// Host processor model that toggles the watchdog kick input.
`timescale 1ns/1ps
module host_kicker #(
	parameter int PERIOD = 8
) (
	input  wire logic i_clk,
	input  wire logic i_enable,
	output logic      o_kick
);
	int   cnt_q  = 0;
	logic kick_q = 1'h0;
	assign o_kick = kick_q;
	// Each toggle lands well inside the timeout, so every edge clears the timer.
	always @(posedge i_clk) begin
		cnt_q <= (i_enable && cnt_q < PERIOD - 1) ? cnt_q + 1 : 0;
		if (i_enable && cnt_q == PERIOD - 1) kick_q <= ~kick_q;
	end
endmodule : host_kicker

// ---- verification/testbench.sv ----
// Self-checking testbench for the supply supervisor logic.
`timescale 1ns/1ps
module testbench;
	localparam int RST_C = 20;
	localparam int WD_C  = 40;
	logic i_clk, i_rst, i_supply_low, i_manual_reset_n, i_power_fail_sense_in, i_float, kick_en, kick;
	logic o_reset_n, o_watchdog_expired_n, o_power_fail_flag_n;
	int   n_errors    = 0;
	int   checks_done = 0;
	logic [31:0] rng  = 32'hdb6cd327;
	// ****************************************************************
	// Clock, host and design
	// ****************************************************************
	initial begin
		i_clk = 1'h0;
		forever #2 i_clk = ~i_clk;
	end
	host_kicker #(.PERIOD(8)) host (.i_clk(i_clk), .i_enable(kick_en), .o_kick(kick));
	supervisor_reset_watchdog_logic #(.RESET_CYCLES(RST_C), .WD_CYCLES(WD_C)) dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_supply_low(i_supply_low), .i_manual_reset_n(i_manual_reset_n),
		.i_power_fail_sense_in(i_power_fail_sense_in), .i_watchdog_kick_in(kick),
		.i_watchdog_kick_float(i_float), .o_reset_n(o_reset_n),
		.o_watchdog_expired_n(o_watchdog_expired_n), .o_power_fail_flag_n(o_power_fail_flag_n));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	// Outputs are taken by value when the task is called, compared on the next falling edge, and the task returns at that falling edge.
	task automatic compare(input logic got, input logic exp);
		@(negedge i_clk);
		got = (got === exp) ? got : got;
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : compare
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc
	// Gives up after a bound so a stuck reset cannot hang the run.
	task automatic wait_reset_high();
		int k;
		for (k = 0; k < 100 && o_reset_n !== 1'h1; k++) cyc(1);
		if (k == 100) begin
			n_errors++;
			print_verdict();
		end
	endtask : wait_reset_high
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		cyc(5000);
		n_errors++;
		print_verdict();
	end
	initial begin
		i_rst = 1'h1;
		i_supply_low = 1'h0;
		i_manual_reset_n = 1'h1;
		i_power_fail_sense_in = 1'h1;
		i_float = 1'h0;
		kick_en = 1'h1;
		cyc(5);
		i_rst <= 1'h0;
		cyc(10);
		compare(o_reset_n, 1'h0);
		wait_reset_high();
		$display("power-up test done");
		for (int i = 0; i < 8; i++) begin
			rng = xorshift(rng);
			i_power_fail_sense_in <= rng[0];
			cyc(8);
			compare(o_power_fail_flag_n, rng[0]);
		end
		$display("power-fail test done");
		i_manual_reset_n <= 1'h0;
		cyc(8);
		compare(o_reset_n, 1'h0);
		i_manual_reset_n <= 1'h1;
		cyc(RST_C);
		compare(o_reset_n, 1'h0);
		cyc(10);
		compare(o_reset_n, 1'h1);
		$display("manual reset test done");
		cyc(100);
		compare(o_watchdog_expired_n, 1'h1);
		kick_en <= 1'h0;
		cyc(WD_C + 16);
		compare(o_watchdog_expired_n, 1'h0);
		compare(o_reset_n, 1'h1);
		cyc(30);
		compare(o_watchdog_expired_n, 1'h0);
		kick_en <= 1'h1;
		cyc(16);
		compare(o_watchdog_expired_n, 1'h1);
		kick_en <= 1'h0;
		i_float <= 1'h1;
		cyc(WD_C * 3);
		compare(o_watchdog_expired_n, 1'h1);
		$display("watchdog test done");
		i_supply_low <= 1'h1;
		cyc(8);
		compare(o_reset_n, 1'h0);
		compare(o_watchdog_expired_n, 1'h0);
		i_supply_low <= 1'h0;
		cyc(8);
		compare(o_watchdog_expired_n, 1'h1);
		compare(o_reset_n, 1'h0);
		wait_reset_high();
		$display("supply test done");
		print_verdict();
	end
endmodule : testbench
